// ==== logic/rsr_reset_and_stop_release.sv ====
// Reset sequencer with STOP standby entry and release.
// Assumes the reset pin, watchdog pulse and wake inputs are synchronous to i_core_clk.
`timescale 1ns/1ps
module rsr_reset_and_stop_release #(
	parameter int WAIT_CYCLES = rsr_pkg::RSR_STAB_CYCLES
) (
	input  wire logic                  i_core_clk,
	input  wire logic                  i_resetn,
	input  wire logic                  i_reset_pin_n,
	input  wire logic                  i_wdt_overflow,
	input  wire logic                  i_stop_exec,
	input  wire logic                  i_cpu_on_main_clk,
	input  wire rsr_pkg::rsr_irq_t     i_irq,
	input  wire logic [7:0]            i_vector_lo,
	input  wire logic [7:0]            i_vector_hi,
	output logic                       o_core_reset,
	output logic                       o_pins_hiz,
	output logic                       o_main_osc_run,
	output logic                       o_sub_osc_run,
	output logic                       o_cpu_run,
	output logic                       o_stop_mode,
	output logic                       o_keep_ram,
	output logic                       o_apply_defaults,
	output logic                       o_vector_service,
	output logic                       o_next_instr,
	output logic [15:0]                o_vector_addr,
	output logic [15:0]                o_fetch_counter,
	output rsr_pkg::rsr_defaults_t     o_defaults
);

	// ***************************************
	// State group
	// ***************************************
	rsr_pkg::rsr_state_t            state;
	rsr_pkg::rsr_state_t            next_state;
	logic [rsr_pkg::RSR_CNT_W-1:0]  wait_cnt;
	logic [rsr_pkg::RSR_CNT_W-1:0]  next_wait_cnt;
	logic [15:0]                    next_fetch_counter;
	logic                           vector_pick;
	logic                           next_vector_pick;
	logic                           next_keep_ram;
	logic                           next_apply_defaults;
	logic                           next_vector_service;
	logic                           next_next_instr;
	logic                           reset_req;
	logic                           terminal;
	logic                           in_reset;

	// Either source lands in the same path
	assign reset_req = !i_reset_pin_n || i_wdt_overflow;
	assign terminal  = wait_cnt == rsr_pkg::RSR_CNT_W'(WAIT_CYCLES - 1);
	assign in_reset  = next_state == rsr_pkg::RSR_RST_HOLD || next_state == rsr_pkg::RSR_RST_WAIT;

	always_comb begin
		next_state          = state;
		next_wait_cnt       = wait_cnt;
		next_fetch_counter  = o_fetch_counter;
		next_vector_pick    = vector_pick;
		next_keep_ram       = o_keep_ram;
		next_apply_defaults = 1'b0;
		next_vector_service = 1'b0;
		next_next_instr     = 1'b0;
		unique case (state)
			rsr_pkg::RSR_RUN: begin
				next_keep_ram = 1'b0;
				if (reset_req) begin
					next_state = rsr_pkg::RSR_RST_HOLD;
				end else if (i_stop_exec && i_cpu_on_main_clk) begin
					next_state = rsr_pkg::RSR_STOP;
				end
			end
			rsr_pkg::RSR_STOP: begin
				if (reset_req) begin
					next_state    = rsr_pkg::RSR_RST_HOLD;
					next_keep_ram = 1'b1;
				end else if (i_irq.pending && !i_irq.request_mask_flag) begin
					next_state       = rsr_pkg::RSR_IRQ_WAIT;
					next_wait_cnt    = '0;
					next_vector_pick = rsr_pkg::rsr_take_vector(i_irq);
				end
			end
			rsr_pkg::RSR_RST_HOLD: begin
				// Count only starts once every source is gone
				next_wait_cnt = '0;
				if (!reset_req) begin
					next_state = rsr_pkg::RSR_RST_WAIT;
				end
			end
			rsr_pkg::RSR_RST_WAIT: begin
				if (reset_req) begin
					next_state = rsr_pkg::RSR_RST_HOLD;
				end else if (terminal) begin
					next_state          = rsr_pkg::RSR_RUN;
					next_fetch_counter  = {i_vector_hi, i_vector_lo};
					next_apply_defaults = 1'b1;
				end else begin
					next_wait_cnt = wait_cnt + 1'b1;
				end
			end
			rsr_pkg::RSR_IRQ_WAIT: begin
				if (reset_req) begin
					next_state    = rsr_pkg::RSR_RST_HOLD;
					next_keep_ram = 1'b1;
				end else if (terminal) begin
					next_state          = rsr_pkg::RSR_RUN;
					next_vector_service = vector_pick;
					next_next_instr     = !vector_pick;
				end else begin
					next_wait_cnt = wait_cnt + 1'b1;
				end
			end
			default: begin
				next_state = rsr_pkg::RSR_RST_HOLD;
			end
		endcase
	end

	// Power-up starts inside the stabilization wait
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state            <= rsr_pkg::RSR_RST_WAIT;
			wait_cnt         <= '0;
			vector_pick      <= 1'b0;
			o_fetch_counter  <= rsr_pkg::RSR_FETCH_RESET;
			o_keep_ram       <= 1'b0;
			o_apply_defaults <= 1'b0;
			o_vector_service <= 1'b0;
			o_next_instr     <= 1'b0;
		end else begin
			state            <= next_state;
			wait_cnt         <= next_wait_cnt;
			vector_pick      <= next_vector_pick;
			o_fetch_counter  <= next_fetch_counter;
			o_keep_ram       <= next_keep_ram;
			o_apply_defaults <= next_apply_defaults;
			o_vector_service <= next_vector_service;
			o_next_instr     <= next_next_instr;
		end
	end

	// ***************************************
	// Pin and clock control group
	// ***************************************
	logic next_core_reset;
	logic next_pins_hiz;
	logic next_main_osc_run;
	logic next_cpu_run;
	logic next_stop_mode;

	always_comb begin
		next_core_reset   = in_reset;
		next_pins_hiz     = in_reset;
		// Main oscillator idle in reset hold and STOP; subsystem runs on
		next_main_osc_run = next_state != rsr_pkg::RSR_RST_HOLD
			&& next_state != rsr_pkg::RSR_STOP;
		next_cpu_run      = next_state == rsr_pkg::RSR_RUN;
		next_stop_mode    = next_state == rsr_pkg::RSR_STOP;
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_core_reset   <= 1'b1;
			o_pins_hiz     <= 1'b1;
			o_main_osc_run <= 1'b1;
			o_sub_osc_run  <= 1'b1;
			o_cpu_run      <= 1'b0;
			o_stop_mode    <= 1'b0;
			o_vector_addr  <= rsr_pkg::RSR_VECTOR_ADDR;
			o_defaults     <= rsr_pkg::RSR_DEFAULTS;
		end else begin
			o_core_reset   <= next_core_reset;
			o_pins_hiz     <= next_pins_hiz;
			o_main_osc_run <= next_main_osc_run;
			o_sub_osc_run  <= 1'b1;
			o_cpu_run      <= next_cpu_run;
			o_stop_mode    <= next_stop_mode;
			o_vector_addr  <= rsr_pkg::RSR_VECTOR_ADDR;
			o_defaults     <= rsr_pkg::RSR_DEFAULTS;
		end
	end

	// ***************************************
	// Assertions
	// ***************************************
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_resetn);

	sequence s_stop_wake;
		state == rsr_pkg::RSR_STOP && !reset_req && i_irq.pending && !i_irq.request_mask_flag;
	endsequence

	sequence s_wait_done;
		state == rsr_pkg::RSR_IRQ_WAIT && terminal && !reset_req;
	endsequence

	sequence s_reset_done;
		state == rsr_pkg::RSR_RST_WAIT && terminal && !reset_req;
	endsequence

	a_stop_reset_exit: assert property (
		state == rsr_pkg::RSR_STOP && reset_req |=> state == rsr_pkg::RSR_RST_HOLD && o_keep_ram)
		else $error("Reset in STOP did not enter reset hold");

	a_wake_decision: assert property (
		s_stop_wake ##1 (!reset_req && !terminal)[*1] ##0 1'b1 |->
			vector_pick == rsr_pkg::rsr_take_vector($past(i_irq)))
		else $error("Wake decision does not match flags");

	a_wake_outcome: assert property (
		s_wait_done |=> (o_vector_service == vector_pick) && (o_next_instr == !vector_pick)
			&& o_cpu_run)
		else $error("Wake outcome pulse wrong");

	a_mask_holds: assert property (
		state == rsr_pkg::RSR_STOP && !reset_req && i_irq.request_mask_flag |=>
			state == rsr_pkg::RSR_STOP)
		else $error("Masked request left STOP");

	a_both_sources: assert property (
		i_wdt_overflow || !i_reset_pin_n |=> o_core_reset && o_pins_hiz && !o_cpu_run)
		else $error("Reset source not taken");

	a_vector_load: assert property (
		state == rsr_pkg::RSR_RST_WAIT && terminal && !reset_req |=>
			o_fetch_counter == {$past(i_vector_hi), $past(i_vector_lo)} && o_apply_defaults
			&& o_defaults.status_word == rsr_pkg::RSR_STATUS_INIT)
		else $error("Reset vector not loaded");

	a_wait_length: assert property (
		$fell(o_core_reset) |-> $past(state) == rsr_pkg::RSR_RST_WAIT
			&& $past(wait_cnt) == rsr_pkg::RSR_CNT_W'(WAIT_CYCLES - 1))
		else $error("Stabilization wait has wrong length");

	a_pins_float: assert property (
		state == rsr_pkg::RSR_RST_HOLD || state == rsr_pkg::RSR_RST_WAIT |-> o_pins_hiz)
		else $error("Pins driven during reset");

	a_osc_in_reset: assert property (
		state == rsr_pkg::RSR_RST_HOLD |-> !o_main_osc_run && o_sub_osc_run)
		else $error("Oscillator state wrong in reset");

	a_stop_entry: assert property (
		$rose(o_stop_mode) |-> $past(i_stop_exec && i_cpu_on_main_clk))
		else $error("STOP entered without instruction on main clock");

	a_stop_no_main: assert property (
		state == rsr_pkg::RSR_RUN && i_stop_exec && !i_cpu_on_main_clk && !reset_req |=>
			state == rsr_pkg::RSR_RUN)
		else $error("STOP taken without main clock");

	a_wait_restart: assert property (
		state == rsr_pkg::RSR_RST_WAIT && reset_req |=> state == rsr_pkg::RSR_RST_HOLD
			&& o_core_reset)
		else $error("New reset source did not restart the wait");

	a_hold_release: assert property (
		state == rsr_pkg::RSR_RST_HOLD && !reset_req |=> state == rsr_pkg::RSR_RST_WAIT
			&& wait_cnt == '0 && o_main_osc_run)
		else $error("Reset hold did not start the wait");

	a_reset_count: assert property (
		state == rsr_pkg::RSR_RST_WAIT && !reset_req && !terminal |=>
			wait_cnt == $past(wait_cnt) + 1'b1)
		else $error("Reset wait counter did not step");

	a_wake_count: assert property (
		state == rsr_pkg::RSR_IRQ_WAIT && !reset_req && !terminal |=>
			wait_cnt == $past(wait_cnt) + 1'b1)
		else $error("Wake wait counter did not step");

	a_keep_cleared: assert property (
		state == rsr_pkg::RSR_RUN |=> !o_keep_ram)
		else $error("Standby contents kept after a running reset");

	a_wake_reset_keep: assert property (
		state == rsr_pkg::RSR_IRQ_WAIT && reset_req |=> o_keep_ram && o_pins_hiz)
		else $error("Reset in wake wait did not keep contents");

	a_reset_osc: assert property (
		reset_req |=> !o_main_osc_run && o_sub_osc_run)
		else $error("Main oscillator running under a reset source");

	a_run_outputs: assert property (
		o_cpu_run |-> !o_core_reset && !o_pins_hiz && o_main_osc_run)
		else $error("Run outputs inconsistent");

	a_stop_outputs: assert property (
		o_stop_mode |-> !o_cpu_run && !o_main_osc_run && !o_core_reset)
		else $error("STOP outputs inconsistent");

	a_defaults_pulse: assert property (
		s_reset_done |=> o_apply_defaults ##1 !o_apply_defaults)
		else $error("Defaults pulse not one cycle");

	a_defaults_value: assert property (
		o_apply_defaults |-> o_defaults == rsr_pkg::RSR_DEFAULTS)
		else $error("Defaults carrier wrong at reset completion");

	a_fetch_steady: assert property (
		!(state == rsr_pkg::RSR_RST_WAIT && terminal && !reset_req) |=>
			$stable(o_fetch_counter))
		else $error("Fetch counter changed outside reset completion");

	a_wake_one_hot: assert property (
		o_vector_service || o_next_instr |-> !(o_vector_service && o_next_instr) && o_cpu_run)
		else $error("Wake pulses overlap");

endmodule

// ==== inc/rsr_pkg.sv ====
// Constants and carriers for the reset and STOP-release sequencer.
// Assumes one main-clock domain; the clock port is the main oscillator.
// Notes on behaviour
// - Reset input during STOP ends standby, then stabilization wait, then reset processing.
// - Unmasked wake vectors if enabled and high level, or low with service flag.
// - Two reset sources: external reset pin and watchdog runaway overflow.
// - Both resets behave alike and start from the vector at the two lowest bytes.
// - Pin low or watchdog overflow asserts reset and initializes every unit.
// - All pins float during reset and during the stabilization wait after it.
// - Pin high clears reset; execution starts after two to the seventeenth clocks.
// - Watchdog reset clears by itself, then the same stabilization wait applies.
// - Main oscillator stops during reset while the subsystem oscillator keeps running.
// - Reset out of STOP keeps standby contents, yet port pins still float.
// - During reset and wait only the fetch counter may change; others wait.
// - Reset during standby preserves data memory and general registers.
// - After reset fetch counter holds the vector and status word its initial value.
// - Port latches cleared, direction all inputs, resistor options cleared.
// - CPU clock control and settle time select load their initial value.
// - Memory size and expansion RAM size load their values; software rewrites RAM size.
// - First 16-bit timer counter and control registers cleared; captures left alone.
// - Second timer mode cleared; 8-bit timers counters, clocks, modes cleared.
// - Memory expansion, key return select and pin function registers cleared.
// - Unmasked request ends STOP; after wait, vector if enabled else next instruction.
// - STOP entered only by the STOP instruction while running from the main clock.
package rsr_pkg;

	// ***************************************
	// Timing
	// ***************************************
	localparam int RSR_STAB_EXP    = 17;
	localparam int RSR_STAB_CYCLES = 2 ** RSR_STAB_EXP;
	localparam int RSR_CNT_W       = 18;
	localparam logic [15:0] RSR_VECTOR_ADDR = 16'h0000;
	localparam logic [15:0] RSR_FETCH_RESET = 16'h0000;

	// ***************************************
	// Sequencer states
	// ***************************************
	typedef enum logic [4:0] {
		RSR_RUN      = 5'h01,
		RSR_STOP     = 5'h02,
		RSR_RST_HOLD = 5'h04,
		RSR_RST_WAIT = 5'h08,
		RSR_IRQ_WAIT = 5'h10
	} rsr_state_t;

	// ***************************************
	// Carriers
	// ***************************************
	typedef struct packed {
		logic pending;
		logic request_mask_flag;
		logic level_select_flag;
		logic ack_enable_flag;
		logic service_level_flag;
	} rsr_irq_t;

	typedef struct packed {
		logic [7:0]  status_word;
		logic [7:0]  port_latch;
		logic [7:0]  port_direction;
		logic [7:0]  internal_resistor_option;
		logic [7:0]  cpu_clock_control;
		logic [7:0]  settle_time_select;
		logic [7:0]  memory_size_select;
		logic [7:0]  expansion_ram_size;
		logic [7:0]  mem_expansion_mode;
		logic [7:0]  key_return_select;
		logic [7:0]  pin_function;
		logic [15:0] timer0_count;
		logic [7:0]  timer0_control;
		logic [7:0]  timer4_control;
		logic [7:0]  timer5x_count;
		logic [7:0]  timer5x_clock_select;
		logic [7:0]  timer5x_control;
	} rsr_defaults_t;

	// ***************************************
	// Values after reset
	// ***************************************
	localparam logic [7:0]  RSR_STATUS_INIT = 8'h02;
	localparam logic [7:0]  RSR_CLEAR8      = 8'h00;
	localparam logic [7:0]  RSR_DIR_INIT    = 8'hFF;
	localparam logic [7:0]  RSR_CLK_INIT    = 8'h04;
	localparam logic [7:0]  RSR_MEMSZ_INIT  = 8'hCF;
	localparam logic [7:0]  RSR_XRAM_INIT   = 8'h0C;
	localparam logic [7:0]  RSR_XRAM_ADVISE = 8'h09;
	localparam logic [15:0] RSR_CLEAR16     = 16'h0000;

	localparam rsr_defaults_t RSR_DEFAULTS = '{
		status_word:              RSR_STATUS_INIT,
		port_latch:               RSR_CLEAR8,
		port_direction:           RSR_DIR_INIT,
		internal_resistor_option: RSR_CLEAR8,
		cpu_clock_control:        RSR_CLK_INIT,
		settle_time_select:       RSR_CLK_INIT,
		memory_size_select:       RSR_MEMSZ_INIT,
		expansion_ram_size:       RSR_XRAM_INIT,
		mem_expansion_mode:       RSR_CLEAR8,
		key_return_select:        RSR_CLEAR8,
		pin_function:             RSR_CLEAR8,
		timer0_count:             RSR_CLEAR16,
		timer0_control:           RSR_CLEAR8,
		timer4_control:           RSR_CLEAR8,
		timer5x_count:            RSR_CLEAR8,
		timer5x_clock_select:     RSR_CLEAR8,
		timer5x_control:          RSR_CLEAR8
	};

	// Wake decision: vectored service or next instruction
	function automatic logic rsr_take_vector(input rsr_irq_t irq);
		return irq.ack_enable_flag && (!irq.level_select_flag || irq.service_level_flag);
	endfunction

endpackage

// ==== tb/rsr_reset_partner.sv ====
// Model of the external reset source and the watchdog overflow line.
// Assumes the bench raises requests with nonblocking writes at falling edges.
`timescale 1ns/1ps
module rsr_reset_partner #(
	parameter int MIN_LOW = 1000
) (
	input  wire logic i_core_clk,
	input  wire logic i_pin_req,
	input  wire logic i_wdt_req,
	output logic      o_reset_pin_n,
	output logic      o_wdt_overflow
);
	// ********
	// Reset pin and watchdog pulse
	// ********
	int low_cnt;

	initial begin
		o_reset_pin_n = 1'b1;
		o_wdt_overflow = 1'b0;
		low_cnt = 0;
	end

	// Short requests still give a full 10 us low at 100 MHz
	always @(negedge i_core_clk) begin
		if (i_pin_req || (!o_reset_pin_n && low_cnt < MIN_LOW)) begin
			o_reset_pin_n <= 1'b0;
			low_cnt <= low_cnt + 1;
		end else begin
			o_reset_pin_n <= 1'b1;
			low_cnt <= 0;
		end
		o_wdt_overflow <= i_wdt_req;
	end
endmodule

// ==== tb/rsr_reset_and_stop_release_tb.sv ====
// Self-checking bench for the reset and STOP-release sequencer.
// Assumes a 16-cycle stabilization wait and the reset partner model.
`timescale 1ns/1ps
module rsr_reset_and_stop_release_tb;
	// ********
	// Signals and instances
	// ********
	localparam int W = 16;
	logic                   clk, rstn, pin_req, wdt_req, stop_exec, on_main, pin_n, wdt;
	logic                   core_rst, hiz, mosc, sosc, run, stop, keep, apply, vsvc, nxt;
	logic                   exp_v;
	logic [2:0]             flg;
	logic [7:0]             vlo, vhi;
	logic [15:0]            vaddr, fetch;
	rsr_pkg::rsr_irq_t      irq;
	rsr_pkg::rsr_defaults_t defs;
	integer                 seed;
	int                     fails, samples_checked, n, i;

	rsr_reset_and_stop_release #(.WAIT_CYCLES(W)) rsr_reset_and_stop_release_inst (
		.i_core_clk(clk), .i_resetn(rstn), .i_reset_pin_n(pin_n),
		.i_wdt_overflow(wdt), .i_stop_exec(stop_exec), .i_cpu_on_main_clk(on_main),
		.i_irq(irq), .i_vector_lo(vlo), .i_vector_hi(vhi), .o_core_reset(core_rst),
		.o_pins_hiz(hiz), .o_main_osc_run(mosc), .o_sub_osc_run(sosc), .o_cpu_run(run),
		.o_stop_mode(stop), .o_keep_ram(keep), .o_apply_defaults(apply),
		.o_vector_service(vsvc), .o_next_instr(nxt), .o_vector_addr(vaddr),
		.o_fetch_counter(fetch), .o_defaults(defs)
	);

	rsr_reset_partner rsr_reset_partner_inst (
		.i_core_clk(clk), .i_pin_req(pin_req), .i_wdt_req(wdt_req),
		.o_reset_pin_n(pin_n), .o_wdt_overflow(wdt)
	);

	// ********
	// Compares and expectations
	// ********
	task automatic chk1(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic chkd(input rsr_pkg::rsr_defaults_t got, input rsr_pkg::rsr_defaults_t exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	function automatic rsr_pkg::rsr_defaults_t exp_defs();
		rsr_pkg::rsr_defaults_t d;
		d = '0;
		d.status_word = 8'h02;
		d.port_direction = 8'hFF;
		d.cpu_clock_control = 8'h04;
		d.settle_time_select = 8'h04;
		d.memory_size_select = 8'hCF;
		d.expansion_ram_size = 8'h0C;
		return d;
	endfunction

	// ********
	// Sequences
	// ********
	// Counts edges from the first one with no reset source; 0 skips the count
	task automatic check_done(input int en);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
			if (apply !== 1'b1) begin
				chk1(core_rst, 1'b1);
				chk1(hiz, 1'b1);
				chk1(run, 1'b0);
			end
		end while (apply !== 1'b1 && n < 400);
		if (en > 0) chk16(16'(n), 16'(en));
		chk1(run, 1'b1);
		chk1(hiz, 1'b0);
		chk1(stop, 1'b0);
		chk16(fetch, {vhi, vlo});
		chk16(vaddr, 16'h0000);
		chkd(defs, exp_defs());
	endtask

	task automatic pin_reset(input logic in_stop);
		@(negedge clk);
		vlo <= 8'($random(seed));
		vhi <= 8'($random(seed));
		pin_req <= 1'b1;
		@(negedge clk);
		pin_req <= 1'b0;
		wait (pin_n === 1'b0);
		repeat (3) @(negedge clk);
		chk1(mosc, 1'b0);
		chk1(sosc, 1'b1);
		chk1(hiz, 1'b1);
		chk1(keep, in_stop);
		wait (pin_n === 1'b1);
		check_done(W + 1);
	endtask

	task automatic enter_stop(input logic main, input logic exp);
		@(negedge clk);
		on_main <= main;
		stop_exec <= 1'b1;
		@(negedge clk);
		stop_exec <= 1'b0;
		repeat (3) @(negedge clk);
		on_main <= 1'b1;
		chk1(stop, exp);
		chk1(run, !exp);
	endtask

	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ********
	// Clock, watchdog and main sequence
	// ********
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Whole run is a few thousand cycles; this span is far beyond it
	initial begin
		#300000;
		fails++;
		final_report();
	end

	initial begin
		seed = 32'h4377F957;
		fails = 0;
		samples_checked = 0;
		rstn = 1'b0;
		pin_req = 1'b0;
		wdt_req = 1'b0;
		stop_exec = 1'b0;
		on_main = 1'b1;
		irq = '0;
		vlo = 8'($random(seed));
		vhi = 8'($random(seed));
		repeat (8) @(negedge clk);
		rstn <= 1'b1;
		check_done(W);
		$display("test power_on done");
		pin_reset(1'b0);
		$display("test pin_reset done");
		@(negedge clk);
		vlo <= 8'($random(seed));
		vhi <= 8'($random(seed));
		wdt_req <= 1'b1;
		@(negedge clk);
		wdt_req <= 1'b0;
		@(negedge clk);
		check_done(W + 1);
		$display("test watchdog_reset done");
		enter_stop(1'b0, 1'b0);
		$display("test stop_refused done");
		// All eight flag mixes, then random ones
		for (i = 0; i < 12; i++) begin
			enter_stop(1'b1, 1'b1);
			flg = (i < 8) ? i[2:0] : 3'($random(seed));
			irq <= '{1'b1, 1'b1, flg[2], flg[1], flg[0]};
			repeat (6) @(negedge clk);
			chk1(stop, 1'b1);
			irq.request_mask_flag <= 1'b0;
			exp_v = flg[1] && (!flg[2] || flg[0]);
			n = 0;
			do begin
				@(posedge clk);
				#1;
				n++;
			end while (!(vsvc === 1'b1 || nxt === 1'b1) && n < 400);
			chk1(vsvc, exp_v);
			chk1(nxt, !exp_v);
			chk1(n > W, 1'b1);
			chk1(run, 1'b1);
			@(negedge clk);
			irq <= '0;
		end
		$display("test stop_wake done");
		enter_stop(1'b1, 1'b1);
		pin_reset(1'b1);
		$display("test stop_reset done");
		final_report();
	end
endmodule
